// file: verilog/mmd_decode.sv
// program counter and banked data memory decoder with shared gpr ram
// Operation
// - the program counter is 13 bits wide and addresses 8K words of 14 bits.
// - only words 0000h-03FFh exist and higher fetch addresses wrap onto them.
// - reset starts execution at 0000h and a taken interrupt loads 0004h.
// - data memory has two banks whose lowest 32 locations are special registers.
// - addresses 20h-5Fh select one shared 64-byte ram reached from either bank.
// - any location that is neither special register nor shared ram reads zero.
// - status bit 5 selects bank 0 when low and bank 1 when high for direct access; pointer bit 7 selects the bank for indirect access.
// - the shared ram is reached directly or through the indirect pointer register.
`include "mmd_params.svh"

module mmd_decode
   import mmd_pkg::*;
(
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   input  wire logic                        pc_load,
   input  wire logic [`MMD_PC_W-1:0]        pc_load_val,
   input  wire logic                        pc_inc,
   input  wire logic                        int_take,
   input  wire logic [7:0]                  status_reg,
   input  wire logic [7:0]                  indirect_pointer_register,
   input  wire mmd_pkg::mmd_dreq_t          dreq,
   input  wire logic [7:0]                  sfr_rdata,
   output logic [`MMD_PC_W-1:0]             pc,
   output logic [`MMD_PMEM_AW-1:0]          pmem_addr,
   output mmd_pkg::mmd_dec_t                dec,
   output logic                             sfr_wr,
   output logic                             sfr_rd,
   output logic [7:0]                       rdata,
   output logic                             reserved_bits_set
);
   import mmd_pkg::*;

   // ---------------------------------------------------------------------
   // program counter
   // ---------------------------------------------------------------------
   logic [`MMD_PC_W-1:0] pc_q;
   logic [`MMD_PC_W-1:0] pc_d;

   assign pc_d = int_take ? `MMD_INT_VEC :
                 pc_load  ? pc_load_val :
                 pc_inc   ? pc_q + `MMD_PC_W'(1) : pc_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_q <= `MMD_RESET_VEC;
      end else begin
         pc_q <= pc_d;
      end
   end

   assign pc        = pc_q;
   assign pmem_addr = pc_q[`MMD_PMEM_AW-1:0];

   // ---------------------------------------------------------------------
   // data address decode
   // ---------------------------------------------------------------------
   function automatic mmd_sel_t region(input logic [`MMD_FADDR_W-1:0] a);
      if (a <= `MMD_SFR_LAST) begin
         region = MMD_SEL_SFR;
      end else if (a <= `MMD_GPR_LAST) begin
         region = MMD_SEL_GPR;
      end else begin
         region = MMD_SEL_NONE;
      end
   endfunction

   wire                     bank_select_bit   = status_reg[`MMD_STAT_BANK_BIT];
   wire                     upper_bank_bit    = status_reg[`MMD_STAT_UPPER];
   wire                     indirect_bank_bit = status_reg[`MMD_STAT_INDIR];
   wire [`MMD_DADDR_W-1:0]  direct_addr       = {bank_select_bit, dreq.faddr};
   wire [`MMD_DADDR_W-1:0]  full_addr         = dreq.indirect ?
                                                indirect_pointer_register :
                                                direct_addr;
   wire [`MMD_FADDR_W-1:0]  low_addr          = full_addr[`MMD_FADDR_W-1:0];
   wire mmd_sel_t           sel               = region(low_addr);
   wire [`MMD_GPR_AW-1:0]   gpr_idx           = `MMD_GPR_AW'(low_addr - `MMD_GPR_FIRST);
   wire                     gpr_hit           = (sel == MMD_SEL_GPR);

   assign dec.sel  = sel;
   assign dec.bank = full_addr[`MMD_DADDR_W-1];
   assign dec.addr = full_addr;
   assign sfr_wr   = dreq.wr && (sel == MMD_SEL_SFR);
   assign sfr_rd   = dreq.rd && (sel == MMD_SEL_SFR);
   assign reserved_bits_set = upper_bank_bit | indirect_bank_bit;

   // ---------------------------------------------------------------------
   // shared general purpose ram, same bytes from both banks
   // ---------------------------------------------------------------------
   logic [7:0] gpr_mem [`MMD_GPR_DEPTH];
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;

   always_ff @(posedge clk) begin
      if (dreq.wr && gpr_hit) begin
         gpr_mem[gpr_idx] <= dreq.wdata;
      end
   end

   always_comb begin
      case (sel)
         MMD_SEL_SFR: rdata_d = sfr_rdata;
         MMD_SEL_GPR: rdata_d = gpr_mem[gpr_idx];
         default:     rdata_d = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else if (dreq.rd) begin
         rdata_q <= rdata_d;
      end
   end

   assign rdata = rdata_q;

   // ---------------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------------
   chk_int_vector_load: assert property (@(posedge clk) disable iff (!rst_n)
      int_take |=> pc == `MMD_INT_VEC)
      else $error("pc not at interrupt vector after interrupt");
   chk_pc_increment: assert property (@(posedge clk) disable iff (!rst_n)
      (pc_inc && !pc_load && !int_take) |=> pc == $past(pc) + `MMD_PC_W'(1))
      else $error("pc did not increment");
   chk_prog_wrap: assert property (@(posedge clk) disable iff (!rst_n)
      pmem_addr == pc[`MMD_PMEM_AW-1:0])
      else $error("program address does not wrap");
   chk_unimpl_zero: assert property (@(posedge clk) disable iff (!rst_n)
      (dreq.rd && sel == MMD_SEL_NONE) |=> rdata == 8'h00)
      else $error("unimplemented location read nonzero");
   chk_sfr_region: assert property (@(posedge clk) disable iff (!rst_n)
      (dreq.rd && dec.addr[6:0] < 7'h20) |-> sfr_rd)
      else $error("low location not decoded as special register");
   chk_gpr_shared: assert property (@(posedge clk) disable iff (!rst_n)
      (dreq.wr && gpr_hit) ##1 (dreq.rd && gpr_hit && !dreq.wr &&
      low_addr == $past(low_addr)) |=> rdata == $past(dreq.wdata, 2))
      else $error("shared ram readback mismatch");
   chk_bank_select: assert property (@(posedge clk) disable iff (!rst_n)
      !dreq.indirect |-> dec.bank == status_reg[5])
      else $error("bank does not follow status bit 5");
   chk_direct_addr: assert property (@(posedge clk) disable iff (!rst_n)
      !dreq.indirect |-> dec.addr[6:0] == dreq.faddr)
      else $error("direct address field lost");
   chk_indirect_addr: assert property (@(posedge clk) disable iff (!rst_n)
      dreq.indirect |-> dec.addr == indirect_pointer_register)
      else $error("indirect address not from pointer");

   // ---------------------------------------------------------------------
   // program counter checks
   // ---------------------------------------------------------------------
   chk_pc_load_val: assert property (@(posedge clk) disable iff (!rst_n)
      (pc_load && !int_take) |=> pc == $past(pc_load_val))
      else $error("pc not loaded with jump target");

   chk_pc_hold: assert property (@(posedge clk) disable iff (!rst_n)
      (!pc_load && !pc_inc && !int_take) |=> pc == $past(pc))
      else $error("pc moved without a control");

   chk_int_priority: assert property (@(posedge clk) disable iff (!rst_n)
      (int_take && pc_load) |=> pc == `MMD_INT_VEC)
      else $error("interrupt did not win over jump");

   // ---------------------------------------------------------------------
   // data decode checks
   // ---------------------------------------------------------------------
   chk_sfr_write: assert property (@(posedge clk) disable iff (!rst_n)
      sfr_wr |-> (dreq.wr && dec.addr[6:0] <= 7'h1f))
      else $error("special register write outside its region");

   chk_sfr_direct: assert property (@(posedge clk) disable iff (!rst_n)
      (dreq.rd && !dreq.indirect && dreq.faddr <= 7'h1f) |-> sfr_rd)
      else $error("direct low read not a special register");

   chk_idle_strobes: assert property (@(posedge clk) disable iff (!rst_n)
      (!dreq.rd && !dreq.wr) |-> (!sfr_rd && !sfr_wr))
      else $error("special register strobe without access");

   chk_sfr_readback: assert property (@(posedge clk) disable iff (!rst_n)
      (dreq.rd && sfr_rd) |=> rdata == $past(sfr_rdata))
      else $error("special register data not returned");

   chk_gpr_region: assert property (@(posedge clk) disable iff (!rst_n)
      (dec.addr[6:0] >= 7'h20 && dec.addr[6:0] <= 7'h5f) |-> dec.sel == MMD_SEL_GPR)
      else $error("shared ram range not decoded");

   chk_no_gpr_strobe: assert property (@(posedge clk) disable iff (!rst_n)
      (dreq.wr && gpr_hit) |-> !sfr_wr)
      else $error("ram write leaked to special registers");

   chk_rdata_hold: assert property (@(posedge clk) disable iff (!rst_n)
      !dreq.rd |=> rdata == $past(rdata))
      else $error("read data changed without a read");

   chk_none_region: assert property (@(posedge clk) disable iff (!rst_n)
      dec.addr[6:0] >= 7'h60 |-> (dec.sel == MMD_SEL_NONE && !sfr_rd && !sfr_wr))
      else $error("unimplemented range decoded as present");

   chk_bank_one: assert property (@(posedge clk) disable iff (!rst_n)
      (!dreq.indirect && status_reg[5]) |-> dec.addr[7])
      else $error("bank one not placed in address");

   chk_reserved_flag: assert property (@(posedge clk) disable iff (!rst_n)
      reserved_bits_set == (status_reg[7] || status_reg[6]))
      else $error("reserved bit flag wrong");

   chk_bank_indirect: assert property (@(posedge clk) disable iff (!rst_n)
      dreq.indirect |-> dec.bank == indirect_pointer_register[7])
      else $error("indirect bank not from pointer");

   chk_direct_width: assert property (@(posedge clk) disable iff (!rst_n)
      !dreq.indirect |-> dec.addr == {status_reg[5], dreq.faddr})
      else $error("direct address not bank above field");

   chk_gpr_direct: assert property (@(posedge clk) disable iff (!rst_n)
      (!dreq.indirect && dreq.faddr >= 7'h20 && dreq.faddr <= 7'h5f) |-> gpr_hit)
      else $error("direct ram access missed");
endmodule // mmd_decode

// file: verilog/mmd_params.svh
// constants for the program and data memory address decoder
`ifndef MMD_PARAMS_SVH
`define MMD_PARAMS_SVH

// ----------------------------------------------------------------------------
// program memory
// ----------------------------------------------------------------------------
`define MMD_PC_W          13
`define MMD_PWORD_W       14
`define MMD_PMEM_AW       10
`define MMD_RESET_VEC     13'h0000
`define MMD_INT_VEC       13'h0004

// ----------------------------------------------------------------------------
// data memory
// ----------------------------------------------------------------------------
`define MMD_DADDR_W       8
`define MMD_FADDR_W       7
`define MMD_SFR_LAST      7'h1f
`define MMD_GPR_FIRST     7'h20
`define MMD_GPR_LAST      7'h5f
`define MMD_GPR_AW        6
`define MMD_GPR_DEPTH     64
`define MMD_STAT_BANK_BIT 5
`define MMD_STAT_UPPER    6
`define MMD_STAT_INDIR    7

`endif

// file: verilog/mmd_pkg.sv
// types for the program and data memory address decoder
package mmd_pkg;
`include "mmd_params.svh"

   typedef enum logic [1:0] {
      MMD_SEL_NONE,
      MMD_SEL_SFR,
      MMD_SEL_GPR
   } mmd_sel_t;

   typedef struct packed {
      logic                      wr;
      logic                      rd;
      logic                      indirect;
      logic [`MMD_FADDR_W-1:0]   faddr;
      logic [7:0]                wdata;
   } mmd_dreq_t;

   typedef struct packed {
      mmd_sel_t                  sel;
      logic                      bank;
      logic [`MMD_DADDR_W-1:0]   addr;
   } mmd_dec_t;
endpackage

// file: verification/tb.sv
// self-checking bench for the program and data memory address decoder
`include "mmd_params.svh"
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import mmd_pkg::*;
   // ---------------------------------------------------------------------
   // stimulus and observation
   // ---------------------------------------------------------------------
   logic                   clk = 1'b0;
   logic                   rst_n = 1'b0;
   logic                   pc_load = 1'b0;
   logic                   pc_inc = 1'b0;
   logic                   int_take = 1'b0;
   logic [`MMD_PC_W-1:0]   pc_load_val = '0;
   logic [7:0]             status_reg = 8'h00;
   logic [7:0]             ptr = 8'h00;
   logic [7:0]             sfr_rdata = 8'h00;
   mmd_dreq_t              dreq = '0;
   logic [`MMD_PC_W-1:0]   pc;
   logic [`MMD_PMEM_AW-1:0] pmem_addr;
   mmd_dec_t               dec;
   logic                   sfr_wr;
   logic                   sfr_rd;
   logic [7:0]             rdata;
   logic                   reserved_bits_set;
   int                     errors = 0;
   int                     checks = 0;
   always #5 clk = ~clk;
   mmd_decode u_dut (.clk(clk), .rst_n(rst_n), .pc_load(pc_load), .pc_load_val(pc_load_val),
      .pc_inc(pc_inc), .int_take(int_take), .status_reg(status_reg),
      .indirect_pointer_register(ptr), .dreq(dreq), .sfr_rdata(sfr_rdata), .pc(pc),
      .pmem_addr(pmem_addr), .dec(dec), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .rdata(rdata),
      .reserved_bits_set(reserved_bits_set));
   // ---------------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic wr, input logic rd, input logic ind, input logic [6:0] fa,
                      input logic [7:0] wd);
      @(posedge clk);
      #1 dreq = '{wr: wr, rd: rd, indirect: ind, faddr: fa, wdata: wd};
      #1;
   endtask
   task automatic fin;
      @(posedge clk);
      #1 dreq = '0;
   endtask
   task automatic pc_op(input logic [2:0] ctl, input logic [12:0] v, input logic [12:0] epc,
                        input logic [9:0] epm);
      @(posedge clk);
      #1 {int_take, pc_load, pc_inc} = ctl;
      pc_load_val = v;
      @(posedge clk);
      #1 {int_take, pc_load, pc_inc} = 3'h0;
      chk(16'(pc), 16'(epc));
      chk(16'(pmem_addr), 16'(epm));
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ---------------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------------
   task automatic t_pc;
      chk(16'(pc), 16'h0000);
      pc_op(3'h2, 13'h1ffe, 13'h1ffe, 10'h3fe);
      pc_op(3'h1, 13'h0000, 13'h1fff, 10'h3ff);
      pc_op(3'h1, 13'h0000, 13'h0000, 10'h000);
      pc_op(3'h2, 13'h0400, 13'h0400, 10'h000);
      pc_op(3'h3, 13'h0155, 13'h0155, 10'h155);
      pc_op(3'h7, 13'h0123, 13'h0004, 10'h004);
   endtask
   task automatic t_gpr;
      acc(1'b1, 1'b0, 1'b0, 7'h20, 8'haa);
      chk(16'(dec), 16'({MMD_SEL_GPR, 1'b0, 8'h20}));
      status_reg = 8'h20;
      acc(1'b0, 1'b1, 1'b0, 7'h20, 8'h00);
      chk(16'(dec), 16'({MMD_SEL_GPR, 1'b1, 8'ha0}));
      ptr = 8'hdf;
      acc(1'b1, 1'b0, 1'b1, 7'h00, 8'h5c);
      chk(16'(rdata), 16'h00aa);
      status_reg = 8'h00;
      acc(1'b0, 1'b1, 1'b0, 7'h5f, 8'h00);
      fin();
      chk(16'(rdata), 16'h005c);
   endtask
   task automatic t_sfr;
      status_reg = 8'h20;
      sfr_rdata = 8'h3c;
      acc(1'b0, 1'b1, 1'b0, 7'h1f, 8'h00);
      chk(16'({sfr_rd, sfr_wr, dec}), 16'({2'b10, MMD_SEL_SFR, 1'b1, 8'h9f}));
      acc(1'b1, 1'b0, 1'b0, 7'h03, 8'h11);
      chk(16'({sfr_rd, sfr_wr, dec}), 16'({2'b01, MMD_SEL_SFR, 1'b1, 8'h83}));
      chk(16'(rdata), 16'h003c);
   endtask
   task automatic t_unimpl;
      status_reg = 8'h00;
      acc(1'b1, 1'b0, 1'b0, 7'h60, 8'hff);
      chk(16'({sfr_rd, sfr_wr, dec.sel}), 16'({2'b00, MMD_SEL_NONE}));
      acc(1'b0, 1'b1, 1'b0, 7'h60, 8'h00);
      fin();
      chk(16'(rdata), 16'h0000);
      status_reg = 8'h40;
      #1 chk(16'(reserved_bits_set), 16'h0001);
      status_reg = 8'h20;
      #1 chk(16'(reserved_bits_set), 16'h0000);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      #1 rst_n = 1'b1;
      t_pc();
      t_gpr();
      t_sfr();
      t_unimpl();
      tally_and_finish();
   end
   initial begin
      #20000;
      errors++;
      tally_and_finish();
   end
endmodule // tb
